// ---- core/gpio_port.sv ----
// Two 16-bit GPIO ports with atomic aliases, merging and change notification.
// Assumes pin inputs are asynchronous and the pad wires out, oe and pulls together.
//
// Summary of operation
// - Set, clear and invert writes touch only bits written as one.
// - Alias reads are undefined; this block answers them with zero.
// - Direction bit one makes a pin input, zero makes it output.
// - Every pin comes out of reset as an input.
// - Latch drives output pins; pin reads return pins; pin writes go to latch.
// - Open-drain bit makes an output drive low only.
// - Pins selected analog read back as zero.
// - Analog select resets to all ones.
// - Analog output pins still drive their digital level.
// - Pin reads return the level three clocks old.
// - Merge maps the upper port into bits 31 to 16 of the lower.
// - Only the lower port may merge with the next higher one.
// - Change flags and the request work only while control bit 15 is set; status updates always.
// - Style zero: enable-low flags mismatch against last read state.
// - Style one: high/low pair picks off, rising, falling or both edges.
// - Status shows pins changed since their last pin read.
// - Flags set on detected events and hold until software clears.
// - Notification only for pins configured as inputs.
// - Detection runs on the always-on clock, also during sleep.
// - Pull-up and pull-down enables act independently per pin.
`timescale 1ns/1ps

module gpio_port (
	input  wire logic                                 clk,
	input  wire logic                                 rst,
	input  wire logic                                 wr_en,
	input  wire logic                                 wr_port,
	input  wire gpio_port_pkg::reg_select_type        wr_reg,
	input  wire gpio_port_pkg::write_op_type          wr_op,
	input  wire logic [gpio_port_pkg::DATA_WIDTH-1:0] wr_data,
	input  wire logic                                 rd_en,
	input  wire logic                                 rd_port,
	input  wire gpio_port_pkg::reg_select_type        rd_reg,
	input  wire gpio_port_pkg::write_op_type          rd_op,
	output logic      [gpio_port_pkg::DATA_WIDTH-1:0] rd_data,
	output logic                                      rd_valid,
	input  wire logic                                 port_merge_enable,
	input  wire logic [gpio_port_pkg::DATA_WIDTH-1:0] pin_in,
	output logic      [gpio_port_pkg::DATA_WIDTH-1:0] pin_out,
	output logic      [gpio_port_pkg::DATA_WIDTH-1:0] pin_oe,
	output logic      [gpio_port_pkg::DATA_WIDTH-1:0] pull_up_en,
	output logic      [gpio_port_pkg::DATA_WIDTH-1:0] pull_down_en,
	output logic      [gpio_port_pkg::DATA_WIDTH-1:0] analog_mode,
	output logic      [gpio_port_pkg::PORT_COUNT-1:0] cn_irq
);
	import gpio_port_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	typedef logic [PORT_COUNT-1:0][PORT_WIDTH-1:0] port_word_type;

	typedef struct packed {
		port_word_type             direction;
		port_word_type             latch;
		port_word_type             open_drain;
		port_word_type             analog;
		port_word_type             pull_up;
		port_word_type             pull_down;
		port_word_type             enable_low;
		port_word_type             enable_high;
		port_word_type             status;
		port_word_type             flag;
		port_word_type             last_read;
		port_word_type             prev;
		logic [PORT_COUNT-1:0]     cn_on;
		logic [PORT_COUNT-1:0]     edge_style;
		logic [DATA_WIDTH-1:0]     rd_data;
		logic                      rd_valid;
		logic [DATA_WIDTH-1:0]     pin_out;
		logic [DATA_WIDTH-1:0]     pin_oe;
		logic [PORT_COUNT-1:0]     irq;
	} gpio_state_type;

	gpio_state_type            st;
	gpio_state_type            next_st;
	logic [DATA_WIDTH-1:0]     synced;
	port_word_type             pins;

	pin_sync u_sync (
		.clk    (clk),
		.rst    (rst),
		.raw    (pin_in),
		.synced (synced)
	);

	assign pins = synced;

	// ****************************************************************
	// Helper functions
	// ****************************************************************

	// Applies a base, clear, set or invert write to one register word.
	function automatic logic [15:0] apply_op(input logic [15:0] base, input logic [15:0] data,
			input write_op_type op);
		case (op)
			OP_BASE:   apply_op = data;
			OP_CLEAR:  apply_op = base & ~data;
			OP_SET:    apply_op = base | data;
			OP_INVERT: apply_op = base ^ data;
			default:   apply_op = base;
		endcase
	endfunction : apply_op

	// Returns the readable value of one register of one port.
	function automatic logic [15:0] read_word(input reg_select_type sel, input int p);
		case (sel)
			REG_DIRECTION:   read_word = st.direction[p];
			REG_LATCH:       read_word = st.latch[p];
			REG_PIN_LEVEL:   read_word = pins[p] & ~st.analog[p];
			REG_OPEN_DRAIN:  read_word = st.open_drain[p];
			REG_ANALOG:      read_word = st.analog[p];
			REG_PULL_UP:     read_word = st.pull_up[p];
			REG_PULL_DOWN:   read_word = st.pull_down[p];
			REG_CN_CONTROL:  read_word = (16'(st.cn_on[p]) << CN_ON_BIT)
					| (16'(st.edge_style[p]) << CN_STYLE_BIT);
			REG_ENABLE_LOW:  read_word = st.enable_low[p];
			REG_ENABLE_HIGH: read_word = st.enable_high[p];
			REG_STATUS:      read_word = st.status[p];
			REG_FLAG:        read_word = st.flag[p];
			default:         read_word = ZERO_RESET;
		endcase
	endfunction : read_word

	// ****************************************************************
	// Next-state logic
	// ****************************************************************

	// Writes first, then reads, then hardware events, so an event beats a clear.
	always_comb begin
		logic [15:0] data;
		logic [15:0] cur;
		logic [15:0] ctl;
		logic [15:0] rise;
		logic [15:0] fall;
		logic [15:0] hit;
		logic        sel;
		logic        merged;
		data   = '0;
		cur    = '0;
		ctl    = '0;
		rise   = '0;
		fall   = '0;
		hit    = '0;
		sel    = 1'b0;
		merged = 1'b0;
		next_st = st;
		next_st.rd_valid = 1'b0;
		for (int p = 0; p < PORT_COUNT; p++) begin
			// The upper port rides in bits 31..16 only when the lower port is merged.
			merged = port_merge_enable && (p == 1);
			sel = wr_en && ((wr_port == 1'(p)) || (merged && !wr_port));
			data = (merged && !wr_port) ? wr_data[31:16] : wr_data[15:0];
			if (sel) begin
				case (wr_reg)
					REG_DIRECTION:   next_st.direction[p] = apply_op(st.direction[p], data, wr_op);
					REG_LATCH,
					REG_PIN_LEVEL:   next_st.latch[p] = apply_op(st.latch[p], data, wr_op);
					REG_OPEN_DRAIN:  next_st.open_drain[p] = apply_op(st.open_drain[p], data, wr_op);
					REG_ANALOG:      next_st.analog[p] = apply_op(st.analog[p], data, wr_op);
					REG_PULL_UP:     next_st.pull_up[p] = apply_op(st.pull_up[p], data, wr_op);
					REG_PULL_DOWN:   next_st.pull_down[p] = apply_op(st.pull_down[p], data, wr_op);
					REG_CN_CONTROL: begin
						ctl = apply_op(read_word(REG_CN_CONTROL, p), data, wr_op);
						next_st.cn_on[p] = ctl[CN_ON_BIT];
						next_st.edge_style[p] = ctl[CN_STYLE_BIT];
					end
					REG_ENABLE_LOW:  next_st.enable_low[p] = apply_op(st.enable_low[p], data, wr_op);
					REG_ENABLE_HIGH: next_st.enable_high[p] = apply_op(st.enable_high[p], data, wr_op);
					// Software may only clear flags; a set or invert write would fake events.
					REG_FLAG: begin
						if (wr_op == OP_BASE) begin
							next_st.flag[p] = st.flag[p] & data;
						end else if (wr_op == OP_CLEAR) begin
							next_st.flag[p] = st.flag[p] & ~data;
						end
					end
					default: begin
					end
				endcase
			end
			// A pin read snapshots the levels compared against in mismatch mode.
			if (rd_en && rd_op == OP_BASE && rd_reg == REG_PIN_LEVEL
					&& ((rd_port == 1'(p)) || (merged && !rd_port))) begin
				next_st.status[p] = '0;
				next_st.last_read[p] = pins[p];
			end
			// Detection runs on the free-running clk, so it needs no gated clock.
			cur = pins[p];
			rise = cur & ~st.prev[p];
			fall = ~cur & st.prev[p];
			if (st.edge_style[p]) begin
				hit = (st.enable_low[p] & ~st.enable_high[p] & rise)
					| (st.enable_high[p] & ~st.enable_low[p] & fall)
					| (st.enable_high[p] & st.enable_low[p] & (rise | fall));
			end else begin
				hit = st.enable_low[p] & (cur ^ st.last_read[p]);
			end
			hit = hit & st.direction[p] & {PORT_WIDTH{st.cn_on[p]}};
			next_st.flag[p] = next_st.flag[p] | hit;
			next_st.status[p] = next_st.status[p] | (rise | fall);
			next_st.prev[p] = cur;
			next_st.irq[p] = st.cn_on[p] && |(st.flag[p] & st.direction[p]
					& (st.enable_low[p] | st.enable_high[p]));
			// Open-drain pins only ever drive low; analog pins still drive.
			next_st.pin_oe[p*PORT_WIDTH +: PORT_WIDTH] = ~st.direction[p]
					& ~(st.open_drain[p] & st.latch[p]);
			next_st.pin_out[p*PORT_WIDTH +: PORT_WIDTH] = st.latch[p] & ~st.open_drain[p];
		end
		// Alias reads answer zero; merged reads of the lower port include the upper.
		if (rd_en) begin
			next_st.rd_valid = 1'b1;
			if (rd_op != OP_BASE) begin
				next_st.rd_data = '0;
			end else if (port_merge_enable && !rd_port) begin
				next_st.rd_data = {read_word(rd_reg, 1), read_word(rd_reg, 0)};
			end else begin
				next_st.rd_data = {16'h0000, read_word(rd_reg, int'(rd_port))};
			end
		end
		if (rst) begin
			next_st = '0;
			next_st.direction = {PORT_COUNT{DIRECTION_RESET}};
			next_st.analog = {PORT_COUNT{ANALOG_RESET}};
		end
	end

	// Register the complete state.
	always_ff @(posedge clk) begin
		st <= next_st;
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************

	// All outputs come straight from state flip-flops.
	assign rd_data      = st.rd_data;
	assign rd_valid     = st.rd_valid;
	assign pin_out      = st.pin_out;
	assign pin_oe       = st.pin_oe;
	assign pull_up_en   = st.pull_up;
	assign pull_down_en = st.pull_down;
	assign analog_mode  = st.analog;
	assign cn_irq       = st.irq;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_set_dir_write;
		wr_en && wr_port && wr_reg == REG_DIRECTION && wr_op == OP_SET;
	endsequence

	property p_set_alias;
		s_set_dir_write |=> st.direction[1] == ($past(st.direction[1]) | $past(wr_data[15:0]));
	endproperty
	a_set_alias: assert property (p_set_alias) else $error("Set alias changed wrong bits.");

	property p_reset_values;
		disable iff (1'b0) rst |=> (&st.direction) && (&st.analog) && st.cn_on == '0;
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("Reset values are wrong.");

	property p_input_no_drive;
		(pin_oe & {$past(st.direction[1]), $past(st.direction[0])}) == '0;
	endproperty
	a_input_no_drive: assert property (p_input_no_drive) else $error("Input pin is driven.");

	property p_open_drain_low;
		(pin_oe & pin_out & {$past(st.open_drain[1]), $past(st.open_drain[0])}) == '0;
	endproperty
	a_open_drain_low: assert property (p_open_drain_low) else $error("Open-drain pin drove high.");

	property p_analog_zero;
		rd_en && rd_op == OP_BASE && rd_reg == REG_PIN_LEVEL && !rd_port
			|=> (rd_data[15:0] & $past(st.analog[0])) == '0;
	endproperty
	a_analog_zero: assert property (p_analog_zero) else $error("Analog pin read nonzero.");

	property p_no_flag_when_off;
		!$past(st.cn_on[0]) |-> (st.flag[0] & ~$past(st.flag[0])) == '0;
	endproperty
	a_no_flag_when_off: assert property (p_no_flag_when_off) else $error("Flag set while off.");

	property p_flag_only_inputs;
		(st.flag[0] & ~$past(st.flag[0]) & ~$past(st.direction[0])) == '0;
	endproperty
	a_flag_only_inputs: assert property (p_flag_only_inputs) else $error("Output pin flagged.");

	property p_flag_holds;
		!(wr_en && wr_reg == REG_FLAG) |=> (st.flag[0] & $past(st.flag[0])) == $past(st.flag[0]);
	endproperty
	a_flag_holds: assert property (p_flag_holds) else $error("Flag dropped without a clear.");

	property p_irq_follows;
		st.cn_on[0] && |(st.flag[0] & st.direction[0] & (st.enable_low[0] | st.enable_high[0]))
			|=> cn_irq[0];
	endproperty
	a_irq_follows: assert property (p_irq_follows) else $error("Request missing for a flag.");

endmodule : gpio_port

// ---- core/pin_sync.sv ----
// Three-stage synchroniser for the raw pin levels.
// Assumes pins are asynchronous to clk; only the last stage may be read outside.
`timescale 1ns/1ps

module pin_sync (
	input  wire logic                                 clk,
	input  wire logic                                 rst,
	input  wire logic [gpio_port_pkg::DATA_WIDTH-1:0] raw,
	output logic      [gpio_port_pkg::DATA_WIDTH-1:0] synced
);
	import gpio_port_pkg::*;

	typedef struct packed {
		logic [SYNC_STAGES-1:0][DATA_WIDTH-1:0] stage;
	} sync_state_type;

	sync_state_type st;
	sync_state_type next_st;

	// Shift the pins through the chain; the first stage feeds only the second.
	always_comb begin
		next_st = st;
		next_st.stage[0] = raw;
		for (int i = 1; i < SYNC_STAGES; i++) begin
			next_st.stage[i] = st.stage[i-1];
		end
		if (rst) begin
			next_st = '0;
		end
	end

	// Register the whole chain.
	always_ff @(posedge clk) begin
		st <= next_st;
	end

	assign synced = st.stage[SYNC_STAGES-1];

	property p_sync_delay;
		@(posedge clk) disable iff (rst)
		$past(!rst, 3) |-> synced == $past(raw, 3);
	endproperty
	a_sync_delay: assert property (p_sync_delay) else $error("Pin sample is not three clocks old.");

endmodule : pin_sync

// ---- include/gpio_port_pkg.sv ----
// Constants, register selects and write operations for the two-port GPIO block.
// Assumes a single 50 MHz system clock and a synchronous, active-high reset.
package gpio_port_pkg;

	// ****************************************************************
	// Geometry and timing
	// ****************************************************************
	localparam int PORT_COUNT    = 2;
	localparam int PORT_WIDTH    = 16;
	localparam int DATA_WIDTH    = 32;
	localparam int SYNC_STAGES   = 3;
	localparam int CLOCK_NS      = 20;

	// ****************************************************************
	// Register selects and write operations
	// ****************************************************************
	typedef enum logic [3:0] {
		REG_DIRECTION    = 4'h0,
		REG_LATCH        = 4'h1,
		REG_PIN_LEVEL    = 4'h2,
		REG_OPEN_DRAIN   = 4'h3,
		REG_ANALOG       = 4'h4,
		REG_PULL_UP      = 4'h5,
		REG_PULL_DOWN    = 4'h6,
		REG_CN_CONTROL   = 4'h7,
		REG_ENABLE_LOW   = 4'h8,
		REG_ENABLE_HIGH  = 4'h9,
		REG_STATUS       = 4'hA,
		REG_FLAG         = 4'hB
	} reg_select_type;

	typedef enum logic [1:0] {
		OP_BASE   = 2'b00,
		OP_CLEAR  = 2'b01,
		OP_SET    = 2'b10,
		OP_INVERT = 2'b11
	} write_op_type;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int              CN_ON_BIT       = 15;
	localparam int              CN_STYLE_BIT    = 11;
	localparam logic [15:0]     DIRECTION_RESET = 16'hFFFF;
	localparam logic [15:0]     ANALOG_RESET    = 16'hFFFF;
	localparam logic [15:0]     ZERO_RESET      = 16'h0000;

endpackage : gpio_port_pkg

// ---- test/gpio_port_with_change_notify_bench.sv ----
// Self-checking bench for the two-port GPIO block with change notification.
// Assumes the pad model pin_pads and inputs driven at the falling clock edge.
`timescale 1ns/1ps

module gpio_port_with_change_notify_bench;
	import gpio_port_pkg::*;
	logic clk = 0, rst = 1, wr_en = 0, wr_port = 0, rd_en = 0, rd_port = 0, rd_valid;
	logic port_merge_enable = 0;
	reg_select_type wr_reg = REG_LATCH, rd_reg = REG_LATCH;
	write_op_type wr_op = OP_BASE, rd_op = OP_BASE;
	logic [31:0] wr_data = 0, rd_data, pin_in, pin_out, pin_oe, pull_up_en, pull_down_en;
	logic [31:0] analog_mode, ext_en = 32'hFFFF_FFFF, ext_val = 0, v;
	logic [1:0] cn_irq;
	int errors = 0, n_checks = 0;

	gpio_port dut_u (.clk(clk), .rst(rst), .wr_en(wr_en), .wr_port(wr_port),
		.wr_reg(wr_reg), .wr_op(wr_op), .wr_data(wr_data), .rd_en(rd_en),
		.rd_port(rd_port), .rd_reg(rd_reg), .rd_op(rd_op), .rd_data(rd_data),
		.rd_valid(rd_valid), .port_merge_enable(port_merge_enable), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
		.pull_down_en(pull_down_en), .analog_mode(analog_mode), .cn_irq(cn_irq));
	pin_pads pads_u (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .ext_en(ext_en),
		.ext_val(ext_val), .pin_in(pin_in));

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	initial begin
		forever #(CLOCK_NS / 2) clk = ~clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// One write strobe, then a cycle of rest so the next call never overlaps it.
	task automatic wr(input logic p, input reg_select_type r, input write_op_type o,
		input logic [31:0] d);
		@(negedge clk);
		wr_en = 1'b1;
		wr_port = p;
		wr_reg = r;
		wr_op = o;
		wr_data = d;
		@(negedge clk);
		wr_en = 0;
	endtask : wr

	task automatic rd(input logic p, input reg_select_type r, input write_op_type o);
		@(negedge clk);
		rd_en = 1'b1;
		rd_port = p;
		rd_reg = r;
		rd_op = o;
		@(negedge clk);
		rd_en = 0;
		chk(32'(rd_valid), 1);
		v = rd_data;
	endtask : rd

	task automatic settle();
		repeat (8) @(negedge clk);
	endtask : settle

	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : report_and_stop

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset();
		chk(pin_oe, 0);
		chk(analog_mode, 32'hFFFF_FFFF);
		rd(0, REG_DIRECTION, OP_BASE);
		chk(v, 32'h0000_FFFF);
		rd(1, REG_ANALOG, OP_BASE);
		chk(v, 32'h0000_FFFF);
	endtask : t_reset

	task automatic t_alias();
		wr(0, REG_PIN_LEVEL, OP_BASE, 32'h0000_00F0);
		wr(0, REG_LATCH, OP_SET, 32'h0000_000F);
		wr(0, REG_LATCH, OP_CLEAR, 32'h0000_0003);
		wr(0, REG_LATCH, OP_INVERT, 32'h0000_0101);
		rd(0, REG_LATCH, OP_BASE);
		chk(v, 32'h0000_01FD);
		rd(0, REG_LATCH, OP_SET);
		chk(v, 0);
	endtask : t_alias

	// Low byte becomes output while still analog; the level must reach the pads.
	task automatic t_drive();
		wr(0, REG_DIRECTION, OP_BASE, 32'h0000_FF00);
		@(negedge clk);
		chk(pin_oe & pin_out, 32'h0000_00FD);
		wr(0, REG_OPEN_DRAIN, OP_SET, 32'h0000_0001);
		@(negedge clk);
		chk({pin_oe[15:0], pin_out[0]}, {16'h00FE, 1'b0});
		wr(0, REG_OPEN_DRAIN, OP_CLEAR, 32'h0000_0001);
		wr(1, REG_PULL_UP, OP_BASE, 32'h0000_0003);
		wr(1, REG_PULL_DOWN, OP_BASE, 32'h0000_0006);
		@(negedge clk);
		chk({pull_up_en[31:16], pull_down_en[31:16]}, 32'h0003_0006);
		wr(1, REG_DIRECTION, OP_CLEAR, 32'h0000_00F0);
		wr(1, REG_DIRECTION, OP_SET, 32'h0000_0030);
		rd(1, REG_DIRECTION, OP_BASE);
		chk(v, 32'h0000_FF3F);
		chk(pin_oe[31:16], 16'h00C0);
		wr(1, REG_DIRECTION, OP_SET, 32'h0000_00F0);
	endtask : t_drive

	// Pin 8 stays analog and must read low; pin 9 shows the synchroniser delay.
	task automatic t_read();
		wr(0, REG_ANALOG, OP_BASE, 32'h0000_0100);
		settle();
		@(negedge clk);
		ext_val[9:8] = 2'b11;
		@(negedge clk);
		rd(0, REG_PIN_LEVEL, OP_BASE);
		chk(v, 32'h0000_00FD);
		rd(0, REG_PIN_LEVEL, OP_BASE);
		chk(v, 32'h0000_02FD);
	endtask : t_read

	task automatic t_merge();
		port_merge_enable = 1;
		wr(0, REG_LATCH, OP_SET, 32'h5A5A_0000);
		rd(0, REG_LATCH, OP_BASE);
		chk(v, 32'h5A5A_01FD);
		rd(1, REG_LATCH, OP_BASE);
		chk(v, 32'h0000_5A5A);
		port_merge_enable = 0;
		rd(0, REG_LATCH, OP_BASE);
		chk(v, 32'h0000_01FD);
	endtask : t_merge

	task automatic pin9(input logic b, input logic exp);
		@(negedge clk);
		ext_val[9] = b;
		settle();
		chk(32'(cn_irq), 32'(exp));
	endtask : pin9

	task automatic t_notify();
		wr(0, REG_CN_CONTROL, OP_BASE, 32'h0000_8800);
		wr(0, REG_ENABLE_LOW, OP_BASE, 32'h0000_0208);
		pin9(0, 0);
		pin9(1, 1);
		rd(0, REG_FLAG, OP_BASE);
		chk(v & 32'h0000_0200, 32'h0000_0200);
		rd(0, REG_STATUS, OP_BASE);
		chk(v & 32'h0000_0200, 32'h0000_0200);
		rd(0, REG_PIN_LEVEL, OP_BASE);
		rd(0, REG_STATUS, OP_BASE);
		chk(v & 32'h0000_0200, 0);
		wr(0, REG_FLAG, OP_CLEAR, 32'h0000_0200);
		settle();
		chk(32'(cn_irq[0]), 0);
		wr(0, REG_ENABLE_HIGH, OP_BASE, 32'h0000_0208);
		pin9(0, 1);
		wr(0, REG_FLAG, OP_BASE, 32'h0000_0000);
		wr(0, REG_ENABLE_LOW, OP_CLEAR, 32'h0000_0200);
		pin9(1, 0);
		pin9(0, 1);
		wr(0, REG_FLAG, OP_BASE, 32'h0000_0000);
		wr(0, REG_LATCH, OP_INVERT, 32'h0000_0008);
		settle();
		chk(32'(cn_irq[0]), 0);
		wr(0, REG_CN_CONTROL, OP_BASE, 32'h0000_0800);
		pin9(1, 0);
		wr(0, REG_ENABLE_LOW, OP_SET, 32'h0000_0200);
		wr(0, REG_CN_CONTROL, OP_BASE, 32'h0000_8000);
		rd(0, REG_PIN_LEVEL, OP_BASE);
		settle();
		chk(32'(cn_irq[0]), 0);
		pin9(0, 1);
	endtask : t_notify

	// ****************************************************************
	// Main sequence and watchdog
	// ****************************************************************
	initial begin
		repeat (10) @(negedge clk);
		rst = 0;
		t_reset();
		t_alias();
		t_drive();
		t_read();
		t_merge();
		t_notify();
		report_and_stop();
	end

	// The tests take well under a thousand cycles; a hang is cut off at four thousand.
	initial begin
		#(CLOCK_NS * 4000);
		errors++;
		report_and_stop();
	end
endmodule : gpio_port_with_change_notify_bench

// ---- test/pin_pads.sv ----
// Behavioural model of the pads and board wiring around the GPIO block.
// Assumes one driver wins per pin: the block, then the board, then the weak pulls.
`timescale 1ns/1ps

module pin_pads (
	input  wire logic                                 clk,
	input  wire logic [gpio_port_pkg::DATA_WIDTH-1:0] pin_out,
	input  wire logic [gpio_port_pkg::DATA_WIDTH-1:0] pin_oe,
	input  wire logic [gpio_port_pkg::DATA_WIDTH-1:0] pull_up_en,
	input  wire logic [gpio_port_pkg::DATA_WIDTH-1:0] pull_down_en,
	input  wire logic [gpio_port_pkg::DATA_WIDTH-1:0] ext_en,
	input  wire logic [gpio_port_pkg::DATA_WIDTH-1:0] ext_val,
	output logic      [gpio_port_pkg::DATA_WIDTH-1:0] pin_in
);
	import gpio_port_pkg::*;
	logic [DATA_WIDTH-1:0] last;

	// Resolve each wire; a floating pin flips so it never looks like a held value.
	always_comb begin
		for (int i = 0; i < DATA_WIDTH; i++) begin
			if (pin_oe[i]) begin
				pin_in[i] = pin_out[i];
			end else if (ext_en[i]) begin
				pin_in[i] = ext_val[i];
			end else if (pull_up_en[i]) begin
				pin_in[i] = 1'b1;
			end else if (pull_down_en[i]) begin
				pin_in[i] = 1'b0;
			end else begin
				pin_in[i] = ~last[i];
			end
		end
	end

	// Remember the last level for the floating case.
	always_ff @(posedge clk) begin
		last <= pin_in;
	end
endmodule : pin_pads
